// File: core/tsic_irq.sv
// Pending latches with enable gating and fixed-priority selection.
// Assumes set and clear pulses on core_clk.
`timescale 1ns/1ps
module tsic_irq import tsic_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [NSRC-1:0] req_set,
	input wire logic [NSRC-1:0] req_enable,
	input wire logic [NSRC-1:0] ack_clear,
	output logic [NSRC-1:0] pend_q,
	output logic any_pend,
	output logic [NSRC-1:0] sel_onehot
);
	genvar i;
	generate
		for (i = 0; i < NSRC; i++) begin : g_latch
			// Set wins over the acknowledge clear
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					pend_q[i] <= 1'b0;
				end else if (req_set[i] && req_enable[i]) begin
					pend_q[i] <= 1'b1;
				end else if (ack_clear[i]) begin
					pend_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign any_pend = |pend_q;
	assign sel_onehot = pend_q & (~pend_q + NSRC'(1));
endmodule : tsic_irq

// File: core/tsic_timer.sv
// Free-running 12-bit microsecond timer with high-nibble holding register.
// Assumes latch_hi is a one-cycle strobe on core_clk.
`timescale 1ns/1ps
module tsic_timer import tsic_pkg::*; #(
	parameter int unsigned TICK_DIV = TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	tsic_tmr_if.timer tif
);
	logic [7:0] div_q;
	logic [11:0] cnt_q;
	logic [3:0] hold_q;
	logic tick;

	assign tick = (div_q == 8'(TICK_DIV - 1));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 8'h00;
		end else begin
			div_q <= tick ? 8'h00 : div_q + 8'h01;
		end
	end

	// Wraps at 0xFFF to zero naturally
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 12'h000;
		end else if (tick) begin
			cnt_q <= cnt_q + 12'h001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= 4'h0;
		end else if (tif.latch_hi) begin
			hold_q <= cnt_q[11:8];
		end
	end

	// Requests on every carry into a count bit, so on each rising and falling transition
	assign tif.t128_pulse = tick && (cnt_q[T128_BIT-1:0] == '1);
	assign tif.t1024_pulse = tick && (cnt_q[T1024_BIT-1:0] == '1);
	assign tif.count = cnt_q;
	assign tif.held_hi = hold_q;

	a_hold_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
		tif.latch_hi |=> hold_q == $past(cnt_q[11:8])) else $error("hold not captured");
endmodule : tsic_timer

// File: core/tsic_top.sv
// Timer, processor status/control and interrupt acknowledge sequencing.
// Assumes the CPU core drives I/O strobes and instruction events on core_clk;
// bus_reset and bus_activity come from the serial engine already synchronous.
`timescale 1ns/1ps
module tsic_top import tsic_pkg::*; #(
	parameter int unsigned WAKE_LONG = WAKE_LONG_CYC,
	parameter int unsigned WAKE_SHORT = WAKE_SHORT_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wdog_rst,
	input wire logic [7:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic instr_last,
	input wire logic halt_instr,
	input wire logic disable_irq_instr,
	input wire logic enable_irq_instr,
	input wire logic return_from_isr_instr,
	input wire logic bus_reset,
	input wire logic bus_activity,
	input wire logic [2:0] ep_irq,
	input wire logic [5:0] sp_irq,
	output logic [7:0] io_rdata,
	output logic cpu_run,
	output logic ack_req,
	output logic [15:0] ack_vector,
	output logic wake_done
);
	tsic_tmr_if tif();
	tsic_state_t st_q;
	logic [7:0] gie_q;
	logic [2:0] epie_q;
	logic step_q, gen_q, por_q, wdr_q, busrst_q, pend_q_flag;
	logic [NSRC-1:0] src_set, src_en, ack_clr, pend, sel;
	logic any_pend, wr_psc, take_irq, susp_req;
	logic [26:0] wake_cnt_q;
	logic [7:0] rdata_d;
	logic [15:0] vec_d;

	tsic_timer u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tif(tif)
	);

	assign tif.latch_hi = io_rd && (io_addr == ADDR_TIMER_LO);

	assign src_set = {ep_irq, tif.t1024_pulse, tif.t128_pulse, bus_reset};
	assign src_en = {epie_q, gie_q[2:0]};

	tsic_irq u_irq (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.req_set(src_set),
		.req_enable(src_en),
		.ack_clear(ack_clr),
		.pend_q(pend),
		.any_pend(any_pend),
		.sel_onehot(sel)
	);

	function automatic logic [15:0] vec_of(input logic [NSRC-1:0] oh);
		logic [15:0] v;
		v = VEC_BASE;
		for (int k = 0; k < NSRC; k++) begin
			if (oh[k]) begin
				v = VEC_BASE + VEC_STEP * 16'(k + 1);
			end
		end
		return v;
	endfunction : vec_of

	// Sampling only at instruction end keeps acknowledge aligned to boundaries
	assign take_irq = instr_last && gen_q && any_pend && (st_q == TSIC_RUN);
	assign ack_clr = take_irq ? sel : '0;
	assign wr_psc = io_wr && (io_addr == ADDR_PSC);
	assign susp_req = wr_psc && io_wdata[PSC_SUSP] && !(bus_activity || any_pend);

	// Unused parallel requests are ignored here
	logic unused_sp;
	assign unused_sp = ^sp_irq;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gie_q <= 8'h00;
			epie_q <= 3'h0;
		end else if (wdog_rst) begin
			gie_q <= 8'h00;
			epie_q <= 3'h0;
		end else if (io_wr && io_addr == ADDR_GLOBAL_IE) begin
			gie_q <= io_wdata;
		end else if (io_wr && io_addr == ADDR_EP_IE) begin
			epie_q <= io_wdata[2:0] & EP_IE_MASK;
		end
	end

	// Global enable: acknowledge and DI clear, EI and RETURN_FROM_ISR_INSTR set
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gen_q <= 1'b0;
		end else if (wdog_rst) begin
			gen_q <= 1'b0;
		end else if (take_irq || disable_irq_instr) begin
			gen_q <= 1'b0;
		end else if (enable_irq_instr || return_from_isr_instr) begin
			gen_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			por_q <= 1'b1;
			wdr_q <= 1'b0;
		end else if (wdog_rst) begin
			por_q <= 1'b0;
			wdr_q <= 1'b1;
		end else if (wr_psc) begin
			// Firmware may clear the flag but never set it
			por_q <= por_q & io_wdata[PSC_POR];
			wdr_q <= io_wdata[PSC_WDR];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busrst_q <= 1'b0;
			step_q <= 1'b0;
		end else if (wdog_rst) begin
			busrst_q <= 1'b0;
			step_q <= 1'b0;
		end else begin
			if (bus_reset) begin
				busrst_q <= 1'b1;
			end else if (wr_psc) begin
				busrst_q <= io_wdata[PSC_BUSRST];
			end
			if (wr_psc) begin
				step_q <= io_wdata[PSC_STEP];
			end
		end
	end

	// Recognition sets the flag, acknowledge clears it; new requests win
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q_flag <= 1'b0;
		end else if (wdog_rst) begin
			pend_q_flag <= 1'b0;
		end else if (|(src_set & src_en)) begin
			pend_q_flag <= 1'b1;
		end else if (take_irq) begin
			pend_q_flag <= 1'b0;
		end
	end

	// Run, halt and suspend sequencing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= TSIC_RUN;
		end else if (wdog_rst) begin
			st_q <= TSIC_RUN;
		end else begin
			case (st_q)
				TSIC_RUN: begin
					if (halt_instr && instr_last) begin
						st_q <= TSIC_HALT;
					end else if (step_q && instr_last) begin
						st_q <= TSIC_HALT;
					end else if (wr_psc && !io_wdata[PSC_RUN]) begin
						st_q <= TSIC_HALT;
					end else if (susp_req) begin
						st_q <= TSIC_SUSP;
					end
				end
				TSIC_HALT: begin
					st_q <= TSIC_HALT;
				end
				TSIC_SUSP: begin
					if (any_pend || bus_activity) begin
						st_q <= TSIC_RUN;
					end
				end
				default: begin
					st_q <= TSIC_HALT;
				end
			endcase
		end
	end

	// Start-up delay after wake chosen by power-on flag
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_cnt_q <= 27'h000_0000;
			wake_done <= 1'b1;
		end else if (st_q == TSIC_SUSP && (any_pend || bus_activity)) begin
			wake_cnt_q <= por_q ? 27'(WAKE_LONG - 1) : 27'(WAKE_SHORT - 1);
			wake_done <= 1'b0;
		end else if (wake_cnt_q != 27'h000_0000) begin
			wake_cnt_q <= wake_cnt_q - 27'h000_0001;
		end else begin
			wake_done <= 1'b1;
		end
	end

	always_comb begin
		rdata_d = 8'h00;
		case (io_addr)
			ADDR_TIMER_LO: rdata_d = tif.count[7:0];
			ADDR_TIMER_HI: rdata_d = {4'h0, tif.held_hi};
			ADDR_GLOBAL_IE: rdata_d = gie_q;
			ADDR_EP_IE: rdata_d = {5'h00, epie_q};
			ADDR_PSC: rdata_d = {pend_q_flag, wdr_q, busrst_q, por_q, st_q == TSIC_SUSP, gen_q, step_q,
				st_q != TSIC_HALT};
			default: rdata_d = 8'h00;
		endcase
	end

	assign vec_d = vec_of(sel);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata <= 8'h00;
			cpu_run <= 1'b1;
			ack_req <= 1'b0;
			ack_vector <= 16'h0000;
		end else begin
			io_rdata <= io_rd ? rdata_d : 8'h00;
			cpu_run <= (st_q == TSIC_RUN) && wake_done;
			ack_req <= take_irq;
			ack_vector <= take_irq ? vec_d : ack_vector;
		end
	end

	a_halt_sticks: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q == TSIC_HALT && !wdog_rst) |=> st_q == TSIC_HALT) else $error("halt left");
	a_step_halts: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q == TSIC_RUN && step_q && instr_last && !wdog_rst) |=> st_q == TSIC_HALT) else $error("step");
	a_mask_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(take_irq || disable_irq_instr || enable_irq_instr || return_from_isr_instr || wdog_rst)
		|=> $stable(gen_q)) else $error("mask moved");
	a_susp_block: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q == TSIC_RUN && wr_psc && io_wdata[PSC_SUSP] && bus_activity) |=> st_q != TSIC_SUSP)
		else $error("suspend not ignored");
	// Halt paths are kept out so that only the flag and the run state are judged
	a_busrst_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		(bus_reset && !wdog_rst && !instr_last && !wr_psc)
		|=> busrst_q && (st_q != TSIC_HALT || $past(st_q) == TSIC_HALT)) else $error("bus reset flag");
	a_wdog_load: assert property (@(posedge core_clk) disable iff (!rst_n)
		wdog_rst |=> wdr_q && !por_q && gie_q == 8'h00 && epie_q == 3'h0) else $error("wdog load");
	a_ack_only_end: assert property (@(posedge core_clk) disable iff (!rst_n)
		ack_req |-> $past(instr_last) && !gen_q) else $error("ack off boundary");
	a_ack_vector: assert property (@(posedge core_clk) disable iff (!rst_n)
		(take_irq && sel[SRC_T128]) |=> ack_req && ack_vector == 16'h0004) else $error("vector");
	// Flag, acknowledge, wake and read-path checks
	a_por_only_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
		!por_q |=> !por_q)
		else $error("power-on flag set by write");
	a_pend_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		(|(src_set & src_en) && !wdog_rst) |=> pend_q_flag)
		else $error("pending flag not set");
	a_pend_flag_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		(take_irq && !(|(src_set & src_en)) && !wdog_rst) |=> !pend_q_flag)
		else $error("pending flag not cleared");
	a_ack_clears_src: assert property (@(posedge core_clk) disable iff (!rst_n)
		(take_irq && !(|(sel & src_set & src_en))) |=> (pend & $past(sel)) == '0)
		else $error("latch not cleared");
	a_ack_one_shot: assert property (@(posedge core_clk) disable iff (!rst_n)
		ack_req |=> !ack_req)
		else $error("acknowledge repeated");
	a_wake_start: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q == TSIC_SUSP && (any_pend || bus_activity) && !wdog_rst) |=> st_q == TSIC_RUN && !wake_done)
		else $error("wake not started");
	a_hi_from_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		(io_rd && io_addr == ADDR_TIMER_HI) |=> io_rdata == {4'h0, $past(tif.held_hi)})
		else $error("high byte not held");
	a_ep_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		(io_rd && io_addr == ADDR_EP_IE) |=> io_rdata[7:3] == 5'h00)
		else $error("reserved bits set");
	a_mask_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
		(io_rd && io_addr == ADDR_PSC) |=> io_rdata[PSC_IMASK] == $past(gen_q))
		else $error("mask read");
	a_return_from_isr_instr_enables: assert property (@(posedge core_clk) disable iff (!rst_n)
		(return_from_isr_instr && !take_irq && !disable_irq_instr && !wdog_rst) |=> gen_q)
		else $error("return_from_isr_instr");
endmodule : tsic_top

// File: include/tsic_pkg.sv
// Package for the timer, status and interrupt control block.
// Assumes an 8-bit CPU I/O port with a single-cycle read/write strobe.
package tsic_pkg;
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned TICK_US = 1;
	localparam int unsigned TICK_CYCLES = CLK_MHZ * TICK_US;
	localparam int unsigned TIMER_W = 12;
	// Request bits: bit 7 toggles every 128 us, bit 10 every 1.024 ms
	localparam int unsigned T128_BIT = 7;
	localparam int unsigned T1024_BIT = 10;
	localparam int unsigned WAKE_SHORT_US = 128;
	localparam int unsigned WAKE_LONG_US = 96000;
	localparam int unsigned WAKE_SHORT_CYC = CLK_MHZ * WAKE_SHORT_US;
	localparam int unsigned WAKE_LONG_CYC = CLK_MHZ * WAKE_LONG_US;

	localparam logic [7:0] ADDR_GLOBAL_IE = 8'h20;
	localparam logic [7:0] ADDR_EP_IE = 8'h21;
	localparam logic [7:0] ADDR_TIMER_LO = 8'h24;
	localparam logic [7:0] ADDR_TIMER_HI = 8'h25;
	localparam logic [7:0] ADDR_PSC = 8'hFF;

	localparam int unsigned PSC_RUN = 0;
	localparam int unsigned PSC_STEP = 1;
	localparam int unsigned PSC_IMASK = 2;
	localparam int unsigned PSC_SUSP = 3;
	localparam int unsigned PSC_POR = 4;
	localparam int unsigned PSC_BUSRST = 5;
	localparam int unsigned PSC_WDR = 6;
	localparam int unsigned PSC_PEND = 7;
	localparam logic [7:0] PSC_POR_VAL = 8'h11;
	localparam logic [7:0] PSC_WDR_VAL = 8'h41;
	localparam logic [2:0] EP_IE_MASK = 3'h7;

	// Interrupt sources in vector order; vector = 2 * (index + 1)
	localparam int unsigned NSRC = 6;
	localparam int unsigned SRC_BUSRST = 0;
	localparam int unsigned SRC_T128 = 1;
	localparam int unsigned SRC_T1024 = 2;
	localparam int unsigned SRC_EP0 = 3;
	localparam logic [15:0] VEC_BASE = 16'h0000;
	localparam logic [15:0] VEC_STEP = 16'h0002;

	typedef enum logic [2:0] {
		TSIC_RUN = 3'b001,
		TSIC_HALT = 3'b010,
		TSIC_SUSP = 3'b100
	} tsic_state_t;
endpackage : tsic_pkg

// File: include/tsic_tmr_if.sv
// Carrier between the top block and its timer.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
interface tsic_tmr_if;
	logic [11:0] count;
	logic [3:0] held_hi;
	logic latch_hi;
	logic t128_pulse;
	logic t1024_pulse;
	modport timer (output count, output held_hi, output t128_pulse, output t1024_pulse, input latch_hi);
	modport user (input count, input held_hi, input t128_pulse, input t1024_pulse, output latch_hi);
endinterface : tsic_tmr_if

// File: sim/testbench.sv
// Self-checking bench for the timer, status and interrupt control block.
// Assumes the block's embedded assertions and drives every CPU-side input from here.
`timescale 1ns/1ps
module testbench import tsic_pkg::*;;
	localparam int unsigned W_LONG = 20;
	localparam int unsigned W_SHORT = 10;
	logic core_clk, rst_n, wdog_rst, io_wr, io_rd, instr_last, halt_instr;
	logic disable_irq_instr, enable_irq_instr, return_from_isr_instr, bus_reset, bus_activity;
	logic [7:0] io_addr, io_wdata, io_rdata, a, h, b, h2, v;
	logic [2:0] ep_irq, ep_en;
	logic cpu_run, ack_req, wake_done, acked;
	logic [15:0] ack_vector;
	int n_fail, checked, seed, i, k;
	logic [5:0] want;

	tsic_top #(.WAKE_LONG(W_LONG), .WAKE_SHORT(W_SHORT)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.wdog_rst(wdog_rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
		.instr_last(instr_last), .halt_instr(halt_instr), .disable_irq_instr(disable_irq_instr),
		.enable_irq_instr(enable_irq_instr), .return_from_isr_instr(return_from_isr_instr),
		.bus_reset(bus_reset), .bus_activity(bus_activity), .ep_irq(ep_irq), .sp_irq(6'h00),
		.io_rdata(io_rdata), .cpu_run(cpu_run), .ack_req(ack_req), .ack_vector(ack_vector),
		.wake_done(wake_done));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge core_clk) #1;
		io_addr = ad;
		io_wdata = d;
		io_wr = 1'b1;
		@(posedge core_clk) #1;
		io_wr = 1'b0;
	endtask : wr

	// Two cycles exactly, so timer read spacing is known to the cycle
	task automatic rd(input logic [7:0] ad, output logic [7:0] d);
		@(posedge core_clk) #1;
		io_addr = ad;
		io_rd = 1'b1;
		@(posedge core_clk) #1;
		io_rd = 1'b0;
		d = io_rdata;
	endtask : rd

	// One-cycle instruction events: {return_from_isr_instr, ei, di, halt, last}
	task automatic step(input logic [4:0] e, output logic got_ack);
		@(posedge core_clk) #1;
		{return_from_isr_instr, enable_irq_instr, disable_irq_instr, halt_instr, instr_last} = e;
		@(posedge core_clk) #1;
		{return_from_isr_instr, enable_irq_instr, disable_irq_instr, halt_instr, instr_last} = 5'h00;
		got_ack = ack_req;
	endtask : step

	// Vector of source index s: entries two bytes apart, the first after the reset entry
	function automatic logic [15:0] exp_vec(input int s);
		return VEC_BASE + VEC_STEP * 16'(s + 1);
	endfunction : exp_vec

	// Services every latched request in priority order, lowest index first
	task automatic drain(input logic [5:0] exp_set);
		for (int s = 0; s < 6; s++) begin
			if (exp_set[s]) begin
				step(5'h08, acked);
				step(5'h01, acked);
				chk("ack_req", {15'h0000, acked}, 16'h0001);
				chk("ack_vector", ack_vector, exp_vec(s));
				rd(ADDR_PSC, v);
				chk("psc_imask", {15'h0000, v[2]}, 16'h0000);
			end
		end
		step(5'h08, acked);
		step(5'h01, acked);
		chk("ack_none", {15'h0000, acked}, 16'h0000);
		rd(ADDR_PSC, v);
		chk("psc_pend", {15'h0000, v[7]}, 16'h0000);
	endtask : drain

	task automatic pulse_src(input logic br, input logic [2:0] ep);
		@(posedge core_clk) #1;
		bus_reset = br;
		ep_irq = ep;
		@(posedge core_clk) #1;
		bus_reset = 1'b0;
		ep_irq = 3'h0;
	endtask : pulse_src

	// Suspend already requested; wake takes the start-up delay plus the wake edge and the output register
	task automatic wake(input int exp_cyc);
		repeat (2) @(posedge core_clk) #1;
		chk("susp_run", {15'h0000, cpu_run}, 16'h0000);
		bus_activity = 1'b1;
		k = 0;
		while (cpu_run !== 1'b1 && k < 3 * W_LONG) begin
			@(posedge core_clk) #1;
			k++;
		end
		chk("wake_run", {15'h0000, cpu_run}, 16'h0001);
		chk("wake_cycles", k[15:0], exp_cyc[15:0]);
		chk("wake_done", {15'h0000, wake_done}, 16'h0001);
	endtask : wake

	// Tests need about 56,000 cycles at most, most of it the timer waits
	initial begin
		#(8 * 80000);
		n_fail++;
		end_of_test();
	end

	initial begin
		n_fail = 0;
		checked = 0;
		seed = 32'hf370;
		{wdog_rst, io_wr, io_rd, instr_last, halt_instr, disable_irq_instr} = 6'h00;
		{enable_irq_instr, return_from_isr_instr, bus_reset, bus_activity} = 4'h0;
		io_addr = 8'h00;
		io_wdata = 8'h00;
		ep_irq = 3'h0;
		rst_n = 1'b0;
		repeat (10) @(posedge core_clk);
		#1 rst_n = 1'b1;
		rd(ADDR_PSC, v);
		chk("psc_por", {8'h00, v}, 16'h0011);
		rd(ADDR_EP_IE, v);
		chk("ep_ie_rst", {8'h00, v}, 16'h0000);
		// Coherent timer read: the high byte must come from the hold, not the live count
		rd(ADDR_TIMER_LO, a);
		repeat (37496) @(posedge core_clk);
		rd(ADDR_TIMER_HI, h);
		rd(ADDR_TIMER_LO, b);
		rd(ADDR_TIMER_HI, h2);
		chk("timer_hi_rsvd", {8'h00, h & 8'hF0}, 16'h0000);
		chk("timer_span", {4'h0, h2[3:0], b}, {4'h0, h[3:0], a} + 16'd300);
		// Mask bit ignores writes and follows the EI, DI and RETURN_FROM_ISR_INSTR instructions
		wr(ADDR_PSC, 8'h05);
		rd(ADDR_PSC, v);
		chk("imask_wr", {15'h0000, v[2]}, 16'h0000);
		step(5'h08, acked);
		rd(ADDR_PSC, v);
		chk("imask_ei", {15'h0000, v[2]}, 16'h0001);
		step(5'h04, acked);
		rd(ADDR_PSC, v);
		chk("imask_di", {15'h0000, v[2]}, 16'h0000);
		step(5'h10, acked);
		rd(ADDR_PSC, v);
		chk("imask_return_from_isr_instr", {15'h0000, v[2]}, 16'h0001);
		// Bus reset: flag and request, but the processor keeps running
		wr(ADDR_GLOBAL_IE, 8'h01);
		wr(ADDR_EP_IE, 8'hFF);
		rd(ADDR_EP_IE, v);
		chk("ep_ie_rsvd", {8'h00, v}, 16'h0007);
		pulse_src(1'b1, 3'h1);
		repeat (5) @(posedge core_clk) #1;
		chk("no_ack_midinstr", {15'h0000, ack_req}, 16'h0000);
		rd(ADDR_PSC, v);
		chk("psc_busrst", {8'h00, v & 8'hA1}, 16'h00A1);
		chk("run_busrst", {15'h0000, cpu_run}, 16'h0001);
		drain(6'h09);
		// The 128 us request arrives within one period
		wr(ADDR_GLOBAL_IE, 8'h02);
		step(5'h08, acked);
		k = 0;
		acked = 1'b0;
		while (!acked && k < 17000) begin
			step(5'h01, acked);
			k++;
		end
		chk("t128_ack", {15'h0000, acked}, 16'h0001);
		chk("t128_vec", ack_vector, exp_vec(SRC_T128));
		wr(ADDR_GLOBAL_IE, 8'h00);
		// Random enable masks and event sets; masked sources never latch
		for (i = 0; i < 24; i++) begin
			ep_en = $random(seed);
			k = $random(seed);
			wr(ADDR_GLOBAL_IE, {7'h00, ep_en[0]});
			wr(ADDR_EP_IE, {5'h00, ep_en});
			pulse_src(k[3], k[2:0]);
			want = {k[2:0] & ep_en, 2'b00, k[3] & ep_en[0]};
			drain(want);
		end
		wr(ADDR_GLOBAL_IE, 8'h00);
		wr(ADDR_EP_IE, 8'h00);
		// Suspend, then wake on bus activity; the power-on flag is clear, so the short delay applies
		wr(ADDR_PSC, 8'h09);
		wake(W_SHORT + 2);
		wr(ADDR_PSC, 8'h09);
		repeat (3) @(posedge core_clk) #1;
		chk("susp_refused", {15'h0000, cpu_run}, 16'h0001);
		bus_activity = 1'b0;
		// Single step: one instruction then run clears
		wr(ADDR_PSC, 8'h03);
		step(5'h01, acked);
		repeat (2) @(posedge core_clk);
		rd(ADDR_PSC, v);
		chk("step_run", {14'h0000, cpu_run, v[0]}, 16'h0000);
		wr(ADDR_EP_IE, 8'h05);
		@(posedge core_clk) #1 wdog_rst = 1'b1;
		@(posedge core_clk) #1 wdog_rst = 1'b0;
		rd(ADDR_PSC, v);
		chk("psc_wdog", {8'h00, v}, 16'h0041);
		rd(ADDR_EP_IE, v);
		chk("ep_ie_wdog", {8'h00, v}, 16'h0000);
		wr(ADDR_PSC, 8'h51);
		rd(ADDR_PSC, v);
		chk("por_no_set", {15'h0000, v[4]}, 16'h0000);
		// Halt holds until a reset
		step(5'h03, acked);
		repeat (2) @(posedge core_clk);
		step(5'h01, acked);
		step(5'h01, acked);
		chk("halt_run", {15'h0000, cpu_run}, 16'h0000);
		#1 rst_n = 1'b0;
		repeat (2) @(posedge core_clk);
		#1 rst_n = 1'b1;
		rd(ADDR_PSC, v);
		chk("psc_por2", {8'h00, v}, 16'h0011);
		chk("run_por2", {15'h0000, cpu_run}, 16'h0001);
		// After power-on the long start-up delay applies
		wr(ADDR_PSC, 8'h19);
		wake(W_LONG + 2);
		end_of_test();
	end
endmodule : testbench
